// ---- include/spcs_pkg.sv ----
// Purpose: shared constants, types and decode helpers for the pot command sequencer
// Assumes: serial frames of 8 or 16 clocks, header = 4 address bits + 2 command bits
// Notes: location index 0..5 covers four wipers and two terminal control registers
package spcs_pkg;
  localparam int NUM_LOC = 6;
  localparam int DATA_W = 9;
  localparam int IDX_W = 3;
  localparam int CNT_W = 4;
  localparam int SYNC_W = 4;
  localparam int WORD_W = 16;
  localparam int WIPER_BITS_DEFAULT = 8;

  // bit positions inside the sampled pin vector
  localparam int PIN_SDI = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_CSN = 2;
  localparam int PIN_CSHV = 3;
  localparam logic [SYNC_W-1:0] PIN_IDLE = 4'h4;

  // received bit counts at which a command phase ends (count before increment)
  localparam logic [CNT_W-1:0] BIT_ADDR_DONE = 4'h5;
  localparam logic [CNT_W-1:0] BIT_ERR_SLOT = 4'h6;
  localparam logic [CNT_W-1:0] BIT_SHORT_DONE = 4'h7;
  localparam logic [CNT_W-1:0] BIT_LONG_DONE = 4'hf;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

  localparam logic [3:0] ADDR_WIPER0 = 4'h0;
  localparam logic [3:0] ADDR_WIPER1 = 4'h1;
  localparam logic [3:0] ADDR_TCON0 = 4'h4;
  localparam logic [3:0] ADDR_WIPER2 = 4'h6;
  localparam logic [3:0] ADDR_WIPER3 = 4'h7;
  localparam logic [3:0] ADDR_TCON1 = 4'ha;

  localparam logic [IDX_W-1:0] IDX_WIPER0 = 3'h0;
  localparam logic [IDX_W-1:0] IDX_WIPER1 = 3'h1;
  localparam logic [IDX_W-1:0] IDX_WIPER2 = 3'h2;
  localparam logic [IDX_W-1:0] IDX_WIPER3 = 3'h3;
  localparam logic [IDX_W-1:0] IDX_TCON0 = 3'h4;
  localparam logic [IDX_W-1:0] IDX_TCON1 = 3'h5;
  localparam logic [IDX_W-1:0] IDX_NONE = 3'h7;

  localparam logic [DATA_W-1:0] TERMINAL_CONTROL_REG_RESET = 9'h1ff;

  typedef enum logic [1:0] {
    CMD_WRITE = 2'b00,
    CMD_INC = 2'b01,
    CMD_DEC = 2'b10,
    CMD_READ = 2'b11
  } spcs_cmd_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_ERROR = 2'b10
  } spcs_state_type;

  function automatic logic [IDX_W-1:0] spcs_loc_index(input logic [3:0] addr);
    case (addr)
      ADDR_WIPER0: spcs_loc_index = IDX_WIPER0;
      ADDR_WIPER1: spcs_loc_index = IDX_WIPER1;
      ADDR_WIPER2: spcs_loc_index = IDX_WIPER2;
      ADDR_WIPER3: spcs_loc_index = IDX_WIPER3;
      ADDR_TCON0: spcs_loc_index = IDX_TCON0;
      ADDR_TCON1: spcs_loc_index = IDX_TCON1;
      default: spcs_loc_index = IDX_NONE;
    endcase
  endfunction

  function automatic logic spcs_is_wiper(input logic [3:0] addr);
    spcs_is_wiper = (addr == ADDR_WIPER0) || (addr == ADDR_WIPER1) ||
                    (addr == ADDR_WIPER2) || (addr == ADDR_WIPER3);
  endfunction

  // read and write reach every location, step commands only the wipers
  function automatic logic spcs_pair_valid(input logic [3:0] addr, input spcs_cmd_type cmd);
    if (cmd == CMD_INC || cmd == CMD_DEC) begin
      spcs_pair_valid = spcs_is_wiper(addr);
    end else begin
      spcs_pair_valid = (spcs_loc_index(addr) != IDX_NONE);
    end
  endfunction
endpackage

// ---- include/spcs_mem_if.sv ----
// Purpose: carries location access between sequencer and location store
// Assumes: one write or increment per clock, registered read data
// Notes: loc_idx serves both write and increment
`timescale 1ns/1ns
interface spcs_mem_if import spcs_pkg::*; ();
  logic wr_en;
  logic inc_en;
  logic [IDX_W-1:0] loc_idx;
  logic [DATA_W-1:0] wr_data;
  logic [IDX_W-1:0] rd_idx;
  logic [DATA_W-1:0] rd_data;
  logic [NUM_LOC-1:0][DATA_W-1:0] values;

  modport seq (output wr_en, output inc_en, output loc_idx, output wr_data, output rd_idx,
               input rd_data, input values);
  modport mem (input wr_en, input inc_en, input loc_idx, input wr_data, input rd_idx,
               output rd_data, output values);
endinterface

// ---- logic/spcs_mem.sv ----
// Purpose: volatile wiper and terminal control store with saturating increment
// Assumes: only valid indexes are presented by the sequencer
// Notes: read data registered one clock after rd_idx
`timescale 1ns/1ns
module spcs_mem import spcs_pkg::*; #(
  parameter int WIPER_BITS = WIPER_BITS_DEFAULT
) (
  input wire logic clock,
  input wire logic resetn,
  spcs_mem_if.mem port
);
  localparam logic [DATA_W-1:0] FULL_SCALE = 9'(1 << WIPER_BITS);
  localparam logic [DATA_W-1:0] MID_SCALE = 9'(1 << (WIPER_BITS - 1));
  localparam logic [DATA_W-1:0] STEP = 9'h001;

  generate
    if (WIPER_BITS != 7 && WIPER_BITS != 8) begin : g_bad_width
      $error("WIPER_BITS must be 7 or 8");
    end
  endgenerate

  logic [NUM_LOC-1:0][DATA_W-1:0] cells;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_LOC; i++) begin
        cells[i] <= (i >= int'(IDX_TCON0)) ? TERMINAL_CONTROL_REG_RESET : MID_SCALE;
      end
    end else if (port.wr_en) begin
      cells[port.loc_idx] <= port.wr_data;
    end else if (port.inc_en && cells[port.loc_idx] < FULL_SCALE) begin
      cells[port.loc_idx] <= cells[port.loc_idx] + STEP;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      port.rd_data <= '0;
    end else if (32'(port.rd_idx) < NUM_LOC) begin
      port.rd_data <= cells[port.rd_idx];
    end else begin
      port.rd_data <= '0;
    end
  end

  assign port.values = cells;

  inc_step_a: assert property (@(posedge clock) disable iff (!resetn)
    (port.inc_en && !port.wr_en && cells[port.loc_idx] < FULL_SCALE)
      |=> cells[$past(port.loc_idx)] == $past(cells[port.loc_idx]) + STEP)
    else $error("increment did not add exactly one");

  inc_saturate_a: assert property (@(posedge clock) disable iff (!resetn)
    (port.inc_en && !port.wr_en && cells[port.loc_idx] >= FULL_SCALE)
      |=> $stable(cells))
    else $error("increment changed a wiper at or above full scale");
endmodule

// ---- logic/spcs_top.sv ----
// Purpose: serial command sequencer for a quad volatile potentiometer
// Assumes: clock at 100 MHz, serial clock far slower, mode 0,0 or 1,1 framing
// Notes: decrement is decoded as valid and then does nothing
// Summary of operation
// - back-to-back valid commands run without deselect
// - write is exactly sixteen clocks long
// - high-voltage select behaves like normal select
// - write lands only after sixteenth bit
// - write without exactly sixteen clocks discarded
// - after error ignore commands, output low
// - continuous writes reach volatile locations
// - first six bits are address then command
// - seventh read clock drives the error bit
// - clocks eight to sixteen give data, msb first
// - continuous reads reach every location
// - increment is eight clocks, wipers only
// - seventh increment clock drives the error bit
// - increment adds one at eighth clock
// - increment stops at full scale
// - reserved wiper values block increment
// - continuous increments to the four wipers
// - any valid command may follow an increment
// - error bit high for valid pair, else low
// - commands short of eight-clock multiples ignored
// - deselect resets interface, drops partial command
// - data is command-byte bit plus data byte
`timescale 1ns/1ns
module spcs_top import spcs_pkg::*; #(
  parameter int WIPER_BITS = WIPER_BITS_DEFAULT
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic spi_cs_n,
  input wire logic high_voltage_select_level,
  input wire logic spi_sck,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  output logic command_error_flag,
  output logic [NUM_LOC-1:0][DATA_W-1:0] loc_values
);
  generate
    if (WIPER_BITS != 7 && WIPER_BITS != 8) begin : g_bad_width
      $error("WIPER_BITS must be 7 or 8");
    end
  endgenerate

  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] sync3;
  logic [SYNC_W-1:0] filt;
  logic [SYNC_W-1:0] filt_prev;
  logic active;
  logic sck_rise;
  logic sck_fall;
  logic sdi_bit;
  spcs_state_type state;
  logic [CNT_W-1:0] count;
  logic [WORD_W-2:0] shreg;
  logic [WORD_W-1:0] word;
  logic [5:0] header;
  logic [3:0] cur_addr;
  spcs_cmd_type cur_cmd;
  logic valid_now;
  logic short_cmd;
  logic recv_rise;

  spcs_mem_if mem_bus();

  spcs_mem #(
    .WIPER_BITS(WIPER_BITS)
  ) u_mem (
    .clock(clock),
    .resetn(resetn),
    .port(mem_bus.mem)
  );

  assign pins = {high_voltage_select_level, spi_cs_n, spi_sck, spi_sdi};

  // three stages; a level is believed only once stages two and three agree
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1 <= PIN_IDLE;
      sync2 <= PIN_IDLE;
      sync3 <= PIN_IDLE;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      filt <= PIN_IDLE;
      filt_prev <= PIN_IDLE;
    end else begin
      for (int i = 0; i < SYNC_W; i++) begin
        if (sync2[i] == sync3[i]) begin
          filt[i] <= sync2[i];
        end
      end
      filt_prev <= filt;
    end
  end

  // either select level opens a frame, nothing else differs
  assign active = !filt[PIN_CSN] || filt[PIN_CSHV];
  assign sck_rise = active && filt[PIN_SCK] && !filt_prev[PIN_SCK];
  assign sck_fall = active && !filt[PIN_SCK] && filt_prev[PIN_SCK];
  assign sdi_bit = filt[PIN_SDI];
  assign recv_rise = sck_rise && (state == ST_RECV);

  assign word = {shreg, sdi_bit};
  assign header = {shreg[4:0], sdi_bit};
  // reads reach every location, steps only the four wipers
  assign valid_now = spcs_pair_valid(header[5:2], spcs_cmd_type'(header[1:0]));
  assign short_cmd = (cur_cmd == CMD_INC) || (cur_cmd == CMD_DEC);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      command_error_flag <= 1'b1;
    end else begin
      unique case (state)
        ST_IDLE: begin
          command_error_flag <= 1'b1;
          if (active) begin
            state <= ST_RECV;
          end
        end
        ST_RECV: begin
          if (!active) begin
            state <= ST_IDLE;
          end else if (recv_rise && count == BIT_ADDR_DONE && !valid_now) begin
            state <= ST_ERROR;
            command_error_flag <= 1'b0;
          end
        end
        ST_ERROR: begin
          // only a deselect leaves this state
          if (!active) begin
            state <= ST_IDLE;
            command_error_flag <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
          command_error_flag <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
      shreg <= '0;
    end else if (!active || state != ST_RECV) begin
      count <= '0;
    end else if (sck_rise) begin
      shreg <= word[WORD_W-2:0];
      if (count == BIT_LONG_DONE || (count == BIT_SHORT_DONE && short_cmd)) begin
        count <= '0;
      end else begin
        count <= count + CNT_ONE;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cur_addr <= ADDR_WIPER0;
      cur_cmd <= CMD_WRITE;
      mem_bus.rd_idx <= IDX_WIPER0;
    end else if (recv_rise && count == BIT_ADDR_DONE) begin
      cur_addr <= header[5:2];
      cur_cmd <= spcs_cmd_type'(header[1:0]);
      mem_bus.rd_idx <= spcs_loc_index(header[5:2]);
    end
  end

  // memory changes only when the last clock of a command is seen
  assign mem_bus.wr_en = recv_rise && count == BIT_LONG_DONE && cur_cmd == CMD_WRITE;
  assign mem_bus.inc_en = recv_rise && count == BIT_SHORT_DONE && cur_cmd == CMD_INC;
  assign mem_bus.loc_idx = spcs_loc_index(cur_addr);
  assign mem_bus.wr_data = word[DATA_W-1:0];

  // data bits change on the falling edge so they are settled for the host's rising sample; the error state and deselect set the output at once
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      spi_sdo <= 1'b1;
      spi_sdo_oe <= 1'b0;
    end else begin
      spi_sdo_oe <= active;
      if (!active) begin
        spi_sdo <= 1'b1;
      end else if (state == ST_ERROR) begin
        spi_sdo <= 1'b0;
      end else if (sck_fall) begin
        if (cur_cmd == CMD_READ && count >= BIT_SHORT_DONE) begin
          spi_sdo <= mem_bus.rd_data[BIT_LONG_DONE - count];
        end else begin
          spi_sdo <= 1'b1;
        end
      end
    end
  end

  assign loc_values = mem_bus.values;

  sequence seq_bad_header;
    recv_rise && count == BIT_ADDR_DONE && !valid_now;
  endsequence

  sequence seq_err_slot;
    sck_fall && state == ST_RECV && count == BIT_ERR_SLOT;
  endsequence

  sequence seq_long_done;
    recv_rise && count == BIT_LONG_DONE;
  endsequence

  sequence seq_short_done;
    recv_rise && count == BIT_SHORT_DONE && short_cmd;
  endsequence

  bad_pair_error_a: assert property (@(posedge clock) disable iff (!resetn)
    seq_bad_header |=> state == ST_ERROR && !command_error_flag)
    else $error("invalid header did not raise the error state");

  error_hold_a: assert property (@(posedge clock) disable iff (!resetn)
    (state == ST_ERROR && active) |=> state == ST_ERROR && !spi_sdo &&
      !mem_bus.wr_en && !mem_bus.inc_en)
    else $error("error state left or output not low while selected");

  deselect_reset_a: assert property (@(posedge clock) disable iff (!resetn)
    (!active && state != ST_IDLE) |=> state == ST_IDLE && count == '0)
    else $error("deselect did not reset the interface");

  err_bit_high_a: assert property (@(posedge clock) disable iff (!resetn)
    seq_err_slot |=> spi_sdo)
    else $error("valid header did not drive the error bit high");

  read_msb_a: assert property (@(posedge clock) disable iff (!resetn)
    (sck_fall && state == ST_RECV && cur_cmd == CMD_READ && count == BIT_SHORT_DONE)
      |=> spi_sdo == $past(mem_bus.rd_data[DATA_W-1]))
    else $error("read did not start with the top data bit");

  long_wrap_a: assert property (@(posedge clock) disable iff (!resetn)
    seq_long_done |=> count == '0 && state == ST_RECV)
    else $error("count did not restart after a sixteen clock command");

  short_wrap_a: assert property (@(posedge clock) disable iff (!resetn)
    seq_short_done |=> count == '0 ##1 (count == '0)[*1])
    else $error("count did not restart after an eight clock command");

  write_timing_a: assert property (@(posedge clock) disable iff (!resetn)
    mem_bus.wr_en |-> count == BIT_LONG_DONE && cur_cmd == CMD_WRITE &&
      mem_bus.loc_idx != IDX_NONE)
    else $error("write issued away from the sixteenth clock");

  inc_target_a: assert property (@(posedge clock) disable iff (!resetn)
    mem_bus.inc_en |-> spcs_is_wiper(cur_addr) && count == BIT_SHORT_DONE)
    else $error("increment aimed at a non wiper location");

  hv_select_a: assert property (@(posedge clock) disable iff (!resetn)
    (state == ST_IDLE && filt[PIN_CSHV]) |=> state == ST_RECV)
    else $error("high voltage select did not open a frame");

  // the flag only drops on entry to the error state, never inside a good frame
  flag_in_frame_a: assert property (@(posedge clock) disable iff (!resetn)
    (state == ST_RECV) |-> command_error_flag)
    else $error("error flag low while a frame is being received");

  inc_err_bit_a: assert property (@(posedge clock) disable iff (!resetn)
    (sck_fall && state == ST_RECV && count == BIT_ERR_SLOT && short_cmd) |=> spi_sdo)
    else $error("increment did not drive the error bit high");

  read_lsb_a: assert property (@(posedge clock) disable iff (!resetn)
    (sck_fall && state == ST_RECV && cur_cmd == CMD_READ && count == BIT_LONG_DONE)
      |=> spi_sdo == $past(mem_bus.rd_data[0]))
    else $error("read did not end with the bottom data bit");

  // data byte joined with the command-byte bit must reach the store whole
  write_lands_a: assert property (@(posedge clock) disable iff (!resetn)
    mem_bus.wr_en |=> loc_values[$past(mem_bus.loc_idx)] == $past(word[DATA_W-1:0]))
    else $error("write data did not land in the addressed location");

  // released pin rests high so a listener sees no false data bit
  idle_output_a: assert property (@(posedge clock) disable iff (!resetn)
    !active |=> spi_sdo && !spi_sdo_oe)
    else $error("output not released while deselected");

  sequence seq_cut_frame;
    state == ST_RECV && !active && count != '0;
  endsequence

  partial_drop_a: assert property (@(posedge clock) disable iff (!resetn)
    seq_cut_frame |=> $stable(loc_values))
    else $error("a cut frame changed a location");
endmodule

// ---- testbench/spcs_host_model.sv ----
// Purpose: host side of the serial link, drives select, serial clock and data
// Assumes: mode 0,0 framing, serial clock idle low, data line pulled up when idle
// Notes: one bit takes 12 or 13 system clocks, 125 ns on average
`timescale 1ns/1ns
module spcs_host_model (
  input wire logic clock,
  input wire logic spi_sdo,
  output logic spi_cs_n,
  output logic high_voltage_select_level,
  output logic spi_sck,
  output logic spi_sdi
);
  initial begin
    spi_cs_n = 1'b1;
    high_voltage_select_level = 1'b0;
    spi_sck = 1'b0;
    spi_sdi = 1'b1;
  end

  // high-voltage select leaves the pin high but still selects
  task automatic select(input logic hv);
    @(posedge clock);
    spi_cs_n <= hv;
    high_voltage_select_level <= hv;
    repeat (6) @(posedge clock);
  endtask

  // prompt deselect so no stray serial edge reaches a wiper
  task automatic deselect();
    @(posedge clock);
    spi_cs_n <= 1'b1;
    high_voltage_select_level <= 1'b0;
    repeat (8) @(posedge clock);
  endtask

  // sdo is taken late in each low phase, once the synced fall has landed
  task automatic xfer(input int n, input logic [15:0] word, output logic [15:0] got);
    got = 16'h0000;
    @(posedge clock);
    for (int i = n - 1; i >= 0; i--) begin
      spi_sdi <= word[i];
      repeat (6) @(posedge clock);
      @(negedge clock);
      got = {got[14:0], spi_sdo};
      @(posedge clock);
      spi_sck <= 1'b1;
      repeat (5 + i % 2) @(posedge clock);
      spi_sck <= 1'b0;
    end
    spi_sdi <= 1'b1;
    repeat (10) @(posedge clock);
  endtask
endmodule

// ---- testbench/spi_pot_command_sequencer_bench.sv ----
// Purpose: self-checking bench for the pot command sequencer
// Assumes: default wiper width of eight bits, mid scale 080h after reset
// Notes: table rows run one command per select, chained cases follow
`timescale 1ns/1ns
module spi_pot_command_sequencer_bench import spcs_pkg::*;;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic spi_cs_n, high_voltage_select_level, spi_sck, spi_sdi, spi_sdo, spi_sdo_oe;
  logic command_error_flag;
  logic [NUM_LOC-1:0][DATA_W-1:0] loc_values;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [15:0] got;
  typedef struct {
    logic hv;
    int n;
    logic [15:0] word;
    logic [15:0] exp;
    int idx;
    logic [8:0] val;
  } spcs_row_type;
  // select level, clocks, sent word, expected sdo, location, value after
  spcs_row_type rows [15] = '{
    '{0, 16, 16'h00ff, 16'hffff, 0, 9'h0ff},
    '{1, 8, 16'h0004, 16'h00ff, 0, 9'h100},
    '{0, 8, 16'h0004, 16'h00ff, 0, 9'h100},
    '{1, 16, 16'h0c00, 16'hff00, 0, 9'h100},
    '{0, 16, 16'h63a5, 16'hffff, 2, 9'h1a5},
    '{0, 8, 16'h0064, 16'h00ff, 2, 9'h1a5},
    '{1, 16, 16'ha055, 16'hffff, 5, 9'h055},
    '{0, 16, 16'hac00, 16'hfe55, 5, 9'h055},
    '{0, 16, 16'h7000, 16'hffff, 3, 9'h000},
    '{0, 8, 16'h0074, 16'h00ff, 3, 9'h001},
    '{0, 16, 16'h107f, 16'hffff, 1, 9'h07f},
    '{0, 8, 16'h0018, 16'h00ff, 1, 9'h07f},
    '{0, 16, 16'h2c00, 16'hfc00, 0, 9'h100},
    '{1, 8, 16'h0044, 16'h00fc, 4, 9'h1ff},
    '{0, 16, 16'h40a5, 16'hffff, 4, 9'h0a5}
  };

  always #5 clock = ~clock;

  spcs_top u_spcs_top (
    .clock(clock),
    .resetn(resetn),
    .spi_cs_n(spi_cs_n),
    .high_voltage_select_level(high_voltage_select_level),
    .spi_sck(spi_sck),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe),
    .command_error_flag(command_error_flag),
    .loc_values(loc_values)
  );

  spcs_host_model u_spcs_host_model (
    .clock(clock),
    .spi_sdo(spi_sdo),
    .spi_cs_n(spi_cs_n),
    .high_voltage_select_level(high_voltage_select_level),
    .spi_sck(spi_sck),
    .spi_sdi(spi_sdi)
  );

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // about 39 us of traffic, limit well beyond it
  initial begin
    #300000;
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    for (int k = 0; k < NUM_LOC; k++) begin
      check("reset value", {7'h00, loc_values[k]}, (k < 4) ? 16'h0080 : 16'h01ff);
    end
    check("reset error flag", {15'h0000, command_error_flag}, 16'h0001);
    foreach (rows[r]) begin
      u_spcs_host_model.select(rows[r].hv);
      check("enable in frame", {15'h0000, spi_sdo_oe}, 16'h0001);
      u_spcs_host_model.xfer(rows[r].n, rows[r].word, got);
      check("serial output", got, rows[r].exp);
      u_spcs_host_model.deselect();
      check("location", {7'h00, loc_values[rows[r].idx]}, {7'h00, rows[r].val});
      check("enable idle", {15'h0000, spi_sdo_oe}, 16'h0000);
    end
    // read, increment, write chained under one select
    u_spcs_host_model.select(1'b0);
    u_spcs_host_model.xfer(16, 16'h7c00, got);
    check("chained read", got, 16'hfe01);
    u_spcs_host_model.xfer(8, 16'h0074, got);
    check("chained increment", got, 16'h00ff);
    u_spcs_host_model.xfer(16, 16'h0033, got);
    check("write after increment", got, 16'hffff);
    u_spcs_host_model.deselect();
    check("chained wiper3", {7'h00, loc_values[3]}, 16'h0002);
    check("chained wiper0", {7'h00, loc_values[0]}, 16'h0033);
    // write header then only twelve clocks before deselect
    u_spcs_host_model.select(1'b0);
    u_spcs_host_model.xfer(12, 16'h0035, got);
    u_spcs_host_model.deselect();
    check("partial write", {7'h00, loc_values[0]}, 16'h0033);
    // bad pair, then a good write that must be ignored
    u_spcs_host_model.select(1'b1);
    u_spcs_host_model.xfer(8, 16'h0044, got);
    check("error increment", got, 16'h00fc);
    check("error flag low", {15'h0000, command_error_flag}, 16'h0000);
    u_spcs_host_model.xfer(16, 16'h0011, got);
    check("ignored write output", got, 16'h0000);
    u_spcs_host_model.deselect();
    check("ignored write", {7'h00, loc_values[0]}, 16'h0033);
    check("error flag cleared", {15'h0000, command_error_flag}, 16'h0001);
    final_report();
  end
endmodule
